// ### rtl/gpio_port_top.v
// The register addresses and the plain strobed port were left to the implementer.
`include "gpio_port_consts.vh"

module gpio_port_top (
	input wire CLK_IN,
	input wire RESET_N_IN,
	input wire [`ADDR_W-1:0] ADDR_IN,
	input wire [`DATA_W-1:0] WR_DATA_IN,
	input wire WR_EN_IN,
	input wire RD_EN_IN,
	input wire RMW_IN,
	output reg [`DATA_W-1:0] RD_DATA_OUT,
	input wire STANDBY_IN,
	input wire [`PIN_W-1:0] P4_PIN_IN,
	output wire [`PIN_W-1:0] P4_PIN_OUT,
	output wire [`PIN_W-1:0] P4_PIN_OE_OUT,
	output wire [`PIN_W-1:0] P4_PULLUP_OUT,
	output wire [`PIN_W-1:0] P4_DIGITAL_OUT,
	output reg [`PIN_W-1:0] P4_ANALOG_EN_OUT,
	input wire [`PIN_W-1:0] P5_PIN_IN,
	output wire [`PIN_W-1:0] P5_PIN_OUT,
	output wire [`PIN_W-1:0] P5_PIN_OE_OUT,
	output wire [`PIN_W-1:0] P5_PULLUP_OUT,
	output wire [`PIN_W-1:0] P5_DIGITAL_OUT,
	input wire [`PIN_W-1:0] P5_PERIPH_OE_IN,
	input wire [`PIN_W-1:0] P5_PERIPH_DATA_IN
);

	// register state
	reg [`PIN_W-1:0] port4_data_latch_reg;
	reg [`PIN_W-1:0] port4_direction_reg;
	reg [`PIN_W-1:0] port4_pullup_enable_reg;
	reg [`PIN_W-1:0] analog_input_disable_upper_reg;
	reg [`PIN_W-1:0] port5_data_latch_reg;
	reg [`PIN_W-1:0] port5_direction_reg;
	reg [`PIN_W-1:0] port5_pullup_enable_reg;
	reg standby_pin_state_bit_reg;

	// next values
	reg [`PIN_W-1:0] port4_data_latch_next;
	reg [`PIN_W-1:0] port4_direction_next;
	reg [`PIN_W-1:0] port4_pullup_enable_next;
	reg [`PIN_W-1:0] analog_input_disable_upper_next;
	reg [`PIN_W-1:0] port5_data_latch_next;
	reg [`PIN_W-1:0] port5_direction_next;
	reg [`PIN_W-1:0] port5_pullup_enable_next;
	reg standby_pin_state_bit_next;
	reg [`DATA_W-1:0] rd_data_next;

	// decode
	wire wr_p4_data;
	wire wr_p4_dir;
	wire wr_p4_pull;
	wire wr_ain_dis;
	wire wr_p5_data;
	wire wr_p5_dir;
	wire wr_p5_pull;
	wire wr_stby;
	wire [`PIN_W-1:0] wr_nibble;

	// pin side
	wire [`PIN_W-1:0] p4_level;
	wire [`PIN_W-1:0] p5_level;
	wire [`PIN_W-1:0] p4_read;
	wire [`PIN_W-1:0] p5_read;
	wire pins_hiz;

	// only the low nibble is stored
	assign wr_nibble = WR_DATA_IN[`PIN_W-1:0];

	assign wr_p4_data = WR_EN_IN & (ADDR_IN == `OFF_P4_DATA);
	assign wr_p4_dir = WR_EN_IN & (ADDR_IN == `OFF_P4_DIR);
	assign wr_p4_pull = WR_EN_IN & (ADDR_IN == `OFF_P4_PULL);
	assign wr_ain_dis = WR_EN_IN & (ADDR_IN == `OFF_AIN_DIS);
	assign wr_p5_data = WR_EN_IN & (ADDR_IN == `OFF_P5_DATA);
	assign wr_p5_dir = WR_EN_IN & (ADDR_IN == `OFF_P5_DIR);
	assign wr_p5_pull = WR_EN_IN & (ADDR_IN == `OFF_P5_PULL);
	assign wr_stby = WR_EN_IN & (ADDR_IN == `OFF_STBY_CTRL);

	// pins float only in standby with the standby bit set
	assign pins_hiz = standby_pin_state_bit_reg & STANDBY_IN;

	// register write next values
	always @* begin
		port4_data_latch_next = port4_data_latch_reg;
		port4_direction_next = port4_direction_reg;
		port4_pullup_enable_next = port4_pullup_enable_reg;
		analog_input_disable_upper_next = analog_input_disable_upper_reg;
		port5_data_latch_next = port5_data_latch_reg;
		port5_direction_next = port5_direction_reg;
		port5_pullup_enable_next = port5_pullup_enable_reg;
		standby_pin_state_bit_next = standby_pin_state_bit_reg;
		if (wr_p4_data) begin
			port4_data_latch_next = wr_nibble;
		end
		if (wr_p4_dir) begin
			port4_direction_next = wr_nibble;
		end
		if (wr_p4_pull) begin
			port4_pullup_enable_next = wr_nibble;
		end
		if (wr_ain_dis) begin
			analog_input_disable_upper_next = wr_nibble;
		end
		if (wr_p5_data) begin
			port5_data_latch_next = wr_nibble;
		end
		if (wr_p5_dir) begin
			port5_direction_next = wr_nibble;
		end
		if (wr_p5_pull) begin
			port5_pullup_enable_next = wr_nibble;
		end
		if (wr_stby) begin
			standby_pin_state_bit_next = WR_DATA_IN[`SPL_BIT];
		end
	end

	// read mux, upper bits read zero
	always @* begin
		rd_data_next = `RST_RD_DATA;
		if (RD_EN_IN) begin
			case (ADDR_IN)
				`OFF_P4_DATA: begin
					if (RMW_IN) begin
						rd_data_next = {4'h0, port4_data_latch_reg};
					end else begin
						rd_data_next = {4'h0, p4_read};
					end
				end
				`OFF_P4_DIR: begin
					rd_data_next = {4'h0, port4_direction_reg};
				end
				`OFF_P4_PULL: begin
					rd_data_next = {4'h0, port4_pullup_enable_reg};
				end
				`OFF_AIN_DIS: begin
					rd_data_next = {4'h0, analog_input_disable_upper_reg};
				end
				`OFF_P5_DATA: begin
					if (RMW_IN) begin
						rd_data_next = {4'h0, port5_data_latch_reg};
					end else begin
						rd_data_next = {4'h0, p5_read};
					end
				end
				`OFF_P5_DIR: begin
					rd_data_next = {4'h0, port5_direction_reg};
				end
				`OFF_P5_PULL: begin
					rd_data_next = {4'h0, port5_pullup_enable_reg};
				end
				`OFF_STBY_CTRL: begin
					rd_data_next = `RST_RD_DATA;
					rd_data_next[`SPL_BIT] = standby_pin_state_bit_reg;
				end
				default: begin
					rd_data_next = `RST_RD_DATA;
				end
			endcase
		end
	end

	// port 4 registers
	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			port4_data_latch_reg <= `RST_P4_DATA;
			port4_direction_reg <= `RST_P4_DIR;
			port4_pullup_enable_reg <= `RST_P4_PULL;
			analog_input_disable_upper_reg <= `RST_AIN_DIS;
		end else begin
			port4_data_latch_reg <= port4_data_latch_next;
			port4_direction_reg <= port4_direction_next;
			port4_pullup_enable_reg <= port4_pullup_enable_next;
			analog_input_disable_upper_reg <= analog_input_disable_upper_next;
		end
	end

	// port 5 registers
	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			port5_data_latch_reg <= `RST_P5_DATA;
			port5_direction_reg <= `RST_P5_DIR;
			port5_pullup_enable_reg <= `RST_P5_PULL;
		end else begin
			port5_data_latch_reg <= port5_data_latch_next;
			port5_direction_reg <= port5_direction_next;
			port5_pullup_enable_reg <= port5_pullup_enable_next;
		end
	end

	// standby control
	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			standby_pin_state_bit_reg <= `RST_SPL;
		end else begin
			standby_pin_state_bit_reg <= standby_pin_state_bit_next;
		end
	end

	// read data and analog enables
	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			RD_DATA_OUT <= `RST_RD_DATA;
			P4_ANALOG_EN_OUT <= `RST_AN_EN;
		end else begin
			RD_DATA_OUT <= rd_data_next;
			P4_ANALOG_EN_OUT <= ~analog_input_disable_upper_reg;
		end
	end

	// pin synchronisers
	gpio_pin_sync u_p4_sync (
		.clk_in(CLK_IN),
		.reset_n_in(RESET_N_IN),
		.pin_in(P4_PIN_IN),
		.level_out(p4_level)
	);

	gpio_pin_sync u_p5_sync (
		.clk_in(CLK_IN),
		.reset_n_in(RESET_N_IN),
		.pin_in(P5_PIN_IN),
		.level_out(p5_level)
	);

	genvar i;

	// port 4: push-pull, analog shared, no peripheral outputs
	generate
		for (i = 0; i < `PIN_W; i = i + 1) begin : g_p4
			gpio_pin_cell #(
				.OPEN_DRAIN(0),
				.HAS_PULLUP(1)
			) u_cell (
				.clk_in(CLK_IN),
				.reset_n_in(RESET_N_IN),
				.dir_in(port4_direction_reg[i]),
				.latch_in(port4_data_latch_reg[i]),
				.pull_en_in(port4_pullup_enable_reg[i]),
				.dig_en_in(analog_input_disable_upper_reg[i]),
				.per_oe_in(1'b0),
				.per_data_in(1'b0),
				.hiz_in(pins_hiz),
				.level_in(p4_level[i]),
				.pin_out(P4_PIN_OUT[i]),
				.pin_oe_out(P4_PIN_OE_OUT[i]),
				.pull_out(P4_PULLUP_OUT[i]),
				.digital_out(P4_DIGITAL_OUT[i]),
				.read_out(p4_read[i])
			);
		end
	endgenerate

	// port 5: pins 0 and 1 open drain without pull-up
	generate
		for (i = 0; i < `PIN_W; i = i + 1) begin : g_p5
			gpio_pin_cell #(
				.OPEN_DRAIN((`P5_OD_MASK >> i) & 1),
				.HAS_PULLUP((`P5_PU_MASK >> i) & 1)
			) u_cell (
				.clk_in(CLK_IN),
				.reset_n_in(RESET_N_IN),
				.dir_in(port5_direction_reg[i]),
				.latch_in(port5_data_latch_reg[i]),
				.pull_en_in(port5_pullup_enable_reg[i]),
				.dig_en_in(1'b1),
				.per_oe_in(P5_PERIPH_OE_IN[i]),
				.per_data_in(P5_PERIPH_DATA_IN[i]),
				.hiz_in(pins_hiz),
				.level_in(p5_level[i]),
				.pin_out(P5_PIN_OUT[i]),
				.pin_oe_out(P5_PIN_OE_OUT[i]),
				.pull_out(P5_PULLUP_OUT[i]),
				.digital_out(P5_DIGITAL_OUT[i]),
				.read_out(p5_read[i])
			);
		end
	endgenerate

endmodule // gpio_port_top

// ### rtl/gpio_port_consts.vh
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// register bus geometry
`define ADDR_W 4
`define DATA_W 8
`define PIN_W 4

// register offsets
`define OFF_P4_DATA 4'h0
`define OFF_P4_DIR 4'h1
`define OFF_P4_PULL 4'h2
`define OFF_AIN_DIS 4'h3
`define OFF_P5_DATA 4'h4
`define OFF_P5_DIR 4'h5
`define OFF_P5_PULL 4'h6
`define OFF_STBY_CTRL 4'h7

// field positions
`define SPL_BIT 0

// reset values
`define RST_P4_DATA 4'h0
`define RST_P4_DIR 4'h0
`define RST_P4_PULL 4'h0
`define RST_AIN_DIS 4'h0
`define RST_P5_DATA 4'h0
`define RST_P5_DIR 4'h0
`define RST_P5_PULL 4'h0
`define RST_SPL 1'h0
`define RST_RD_DATA 8'h00
`define RST_AN_EN 4'hF

// open-drain and pull-up presence on port 5
`define P5_OD_MASK 4'h3
`define P5_PU_MASK 4'hC

`endif

// ### rtl/gpio_pin_sync.v
`include "gpio_port_consts.vh"

module gpio_pin_sync (
	input wire clk_in,
	input wire reset_n_in,
	input wire [`PIN_W-1:0] pin_in,
	output reg [`PIN_W-1:0] level_out
);

	reg [`PIN_W-1:0] stage1_reg;
	reg [`PIN_W-1:0] stage2_reg;
	reg [`PIN_W-1:0] stage3_reg;
	wire [`PIN_W-1:0] agree;

	// a change counts once the second and third stage agree
	assign agree = ~(stage2_reg ^ stage3_reg);

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stage1_reg <= 4'h0;
			stage2_reg <= 4'h0;
			stage3_reg <= 4'h0;
			level_out <= 4'h0;
		end else begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			level_out <= (agree & stage3_reg) | (~agree & level_out);
		end
	end

endmodule // gpio_pin_sync

// ### rtl/gpio_pin_cell.v
`include "gpio_port_consts.vh"

module gpio_pin_cell #(
	parameter OPEN_DRAIN = 0,
	parameter HAS_PULLUP = 1
) (
	input wire clk_in,
	input wire reset_n_in,
	input wire dir_in,
	input wire latch_in,
	input wire pull_en_in,
	input wire dig_en_in,
	input wire per_oe_in,
	input wire per_data_in,
	input wire hiz_in,
	input wire level_in,
	output reg pin_out,
	output reg pin_oe_out,
	output reg pull_out,
	output reg digital_out,
	output wire read_out
);

	wire od;
	wire pu;
	wire drive_en;
	wire drive_val;
	wire oe_next;
	wire out_next;
	wire pull_next;
	wire dig_next;

	assign od = (OPEN_DRAIN != 0);
	assign pu = (HAS_PULLUP != 0);
	// peripheral output overrides the latch
	assign drive_en = dir_in | per_oe_in;
	assign drive_val = per_oe_in ? per_data_in : latch_in;
	// open drain releases on a one
	assign oe_next = ~hiz_in & drive_en & ~(od & drive_val);
	assign out_next = drive_val & ~od;
	// pull-up off while driving low
	assign pull_next = pu & pull_en_in & ~(oe_next & ~out_next);
	// digital path blocked by analog select or by standby with the standby bit set
	assign dig_next = dig_en_in & ~hiz_in & level_in;
	// output pins read the latch, inputs read the pin
	assign read_out = dir_in ? latch_in : digital_out;

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_out <= 1'b0;
			pin_oe_out <= 1'b0;
			pull_out <= 1'b0;
			digital_out <= 1'b0;
		end else begin
			pin_out <= out_next;
			pin_oe_out <= oe_next;
			pull_out <= pull_next;
			digital_out <= dig_next;
		end
	end

endmodule // gpio_pin_cell

// ### tb/gpio_port_checker_assertions.sv
`include "gpio_port_consts.vh"
module gpio_port_checker (
	input wire CLK_IN,
	input wire RESET_N_IN,
	input wire [`ADDR_W-1:0] ADDR_IN,
	input wire [`DATA_W-1:0] WR_DATA_IN,
	input wire WR_EN_IN,
	input wire RD_EN_IN,
	input wire [`DATA_W-1:0] RD_DATA_OUT,
	input wire STANDBY_IN,
	input wire [`PIN_W-1:0] P4_PIN_OUT,
	input wire [`PIN_W-1:0] P4_PIN_OE_OUT,
	input wire [`PIN_W-1:0] P4_PULLUP_OUT,
	input wire [`PIN_W-1:0] P4_DIGITAL_OUT,
	input wire [`PIN_W-1:0] P4_ANALOG_EN_OUT,
	input wire [`PIN_W-1:0] P5_PIN_OUT,
	input wire [`PIN_W-1:0] P5_PIN_OE_OUT,
	input wire [`PIN_W-1:0] P5_PULLUP_OUT,
	input wire [`PIN_W-1:0] P5_PERIPH_OE_IN,
	input wire [`PIN_W-1:0] P5_PERIPH_DATA_IN
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	a_unmapped_read:
	assert property ($past(RD_EN_IN) && $past(ADDR_IN) >= 4'h8 |-> RD_DATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	a_upper_bits_zero:
	assert property (RD_DATA_OUT[7:4] == 4'h0) else $error("upper read bits set");
	a_open_drain_low:
	assert property (P5_PIN_OUT[1:0] == 2'h0) else $error("open drain drives high");
	a_pullup_off_low:
	assert property (((P4_PIN_OE_OUT & ~P4_PIN_OUT & P4_PULLUP_OUT)
		| (P5_PIN_OE_OUT & ~P5_PIN_OUT & P5_PULLUP_OUT)) == 4'h0) else $error("pull-up on low");
	a_no_od_pullup:
	assert property (P5_PULLUP_OUT[1:0] == 2'h0) else $error("open drain pull-up");
	a_analog_gate:
	assert property ((P4_DIGITAL_OUT & P4_ANALOG_EN_OUT) == 4'h0) else $error("analog not gated");
	a_periph_drive:
	assert property ($past(P5_PERIPH_OE_IN[2]) && !$past(STANDBY_IN)
		|-> P5_PIN_OE_OUT[2] && P5_PIN_OUT[2] == $past(P5_PERIPH_DATA_IN[2]))
		else $error("peripheral not driving");
	a_dir_out_drive:
	assert property ((WR_EN_IN && ADDR_IN == `OFF_P4_DIR && WR_DATA_IN[0]) ##1 !STANDBY_IN
		|=> P4_PIN_OE_OUT[0]) else $error("output not driven");
	a_dir_in_float:
	assert property ((WR_EN_IN && ADDR_IN == `OFF_P4_DIR && !WR_DATA_IN[0])
		|-> ##2 !P4_PIN_OE_OUT[0]) else $error("input driven");
	a_reset_float:
	assert property ($rose(RESET_N_IN) |-> P4_PIN_OE_OUT == 4'h0 && P5_PIN_OE_OUT == 4'h0)
		else $error("pin driven after reset");
endmodule // gpio_port_checker

bind gpio_port_top gpio_port_checker i_chk (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
	.ADDR_IN(ADDR_IN), .WR_DATA_IN(WR_DATA_IN), .WR_EN_IN(WR_EN_IN), .RD_EN_IN(RD_EN_IN),
	.RD_DATA_OUT(RD_DATA_OUT), .STANDBY_IN(STANDBY_IN), .P4_PIN_OUT(P4_PIN_OUT),
	.P4_PIN_OE_OUT(P4_PIN_OE_OUT), .P4_PULLUP_OUT(P4_PULLUP_OUT),
	.P4_DIGITAL_OUT(P4_DIGITAL_OUT), .P4_ANALOG_EN_OUT(P4_ANALOG_EN_OUT),
	.P5_PIN_OUT(P5_PIN_OUT), .P5_PIN_OE_OUT(P5_PIN_OE_OUT), .P5_PULLUP_OUT(P5_PULLUP_OUT),
	.P5_PERIPH_OE_IN(P5_PERIPH_OE_IN), .P5_PERIPH_DATA_IN(P5_PERIPH_DATA_IN));

// ### tb/gpio_pin_world.sv
module gpio_pin_world (
	input wire clk_in,
	input wire [3:0] drive_in,
	input wire [3:0] oe_in,
	input wire [3:0] pull_in,
	input wire [3:0] ext_en_in,
	input wire [3:0] ext_val_in,
	output logic [3:0] level_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic wobble_reg = 1'b0;
	// undriven lines without pull-up wander every cycle
	always @(posedge clk_in) begin
		wobble_reg <= ~wobble_reg;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			level_out[i] = oe_in[i] ? drive_in[i] : ext_en_in[i] ? ext_val_in[i] :
				pull_in[i] ? 1'b1 : wobble_reg ^ i[0];
		end
	end
endmodule // gpio_pin_world

// ### tb/gpio_port_with_analog_disable_tb_top.sv
module gpio_port_with_analog_disable_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic rmw = 1'b0;
	logic standby = 1'b0;
	logic [3:0] p5_poe = 4'h0;
	logic [3:0] p5_pdat = 4'h0;
	logic [3:0] ext_en = 4'h0;
	logic [3:0] ext_val = 4'h0;
	logic [3:0] ext5_en = 4'h0;
	logic [3:0] ext5_val = 4'h0;
	wire [7:0] rdata;
	wire [3:0] p4_lvl, p4_out, p4_oe, p4_pu, p4_dig, p4_an;
	wire [3:0] p5_lvl, p5_out, p5_oe, p5_pu, p5_dig;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [7:0] d;
	always #12.5 clk = ~clk;
	gpio_port_top i_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WR_DATA_IN(wdata),
		.WR_EN_IN(wr_en), .RD_EN_IN(rd_en), .RMW_IN(rmw), .RD_DATA_OUT(rdata),
		.STANDBY_IN(standby), .P4_PIN_IN(p4_lvl), .P4_PIN_OUT(p4_out), .P4_PIN_OE_OUT(p4_oe),
		.P4_PULLUP_OUT(p4_pu), .P4_DIGITAL_OUT(p4_dig), .P4_ANALOG_EN_OUT(p4_an),
		.P5_PIN_IN(p5_lvl), .P5_PIN_OUT(p5_out), .P5_PIN_OE_OUT(p5_oe), .P5_PULLUP_OUT(p5_pu),
		.P5_DIGITAL_OUT(p5_dig), .P5_PERIPH_OE_IN(p5_poe), .P5_PERIPH_DATA_IN(p5_pdat));
	gpio_pin_world i_w4 (.clk_in(clk), .drive_in(p4_out), .oe_in(p4_oe), .pull_in(p4_pu),
		.ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(p4_lvl));
	gpio_pin_world i_w5 (.clk_in(clk), .drive_in(p5_out), .oe_in(p5_oe), .pull_in(p5_pu),
		.ext_en_in(ext5_en), .ext_val_in(ext5_val), .level_out(p5_lvl));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [3:0] a, input logic m,
		input logic [7:0] exp);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		rmw <= m;
		@(posedge clk);
		rd_en <= 1'b0;
		rmw <= 1'b0;
		#1 check(what, rdata, exp);
	endtask
	// pins settle two edges after a write, inputs five edges after a change
	task automatic settle;
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic t_reset;
		rchk("dir4", 4'h1, 1'b0, 8'h00);
		rchk("aindis", 4'h3, 1'b0, 8'h00);
		check("an_en", p4_an, 4'hF);
		check("p4_oe", p4_oe, 4'h0);
		$display("test reset done");
	endtask
	task automatic t_output;
		wr(4'h1, 8'hFF);
		wr(4'h0, 8'hA5);
		wr(4'h2, 8'hFF);
		settle;
		check("p4_out", p4_out, 4'h5);
		check("p4_oe", p4_oe, 4'hF);
		check("p4_pu", p4_pu, 4'h5);
		rchk("data4", 4'h0, 1'b0, 8'h05);
		rchk("dir4", 4'h1, 1'b0, 8'h0F);
		$display("test output done");
	endtask
	task automatic t_input;
		// external side drives only pins the port leaves as inputs
		@(posedge clk);
		ext_en <= 4'hC;
		ext_val <= 4'h8;
		wr(4'h1, 8'h03);
		wr(4'h3, 8'h0C);
		wr(4'h2, 8'h00);
		settle;
		check("p4_oe", p4_oe, 4'h3);
		check("p4_pu", p4_pu, 4'h0);
		rchk("normal", 4'h0, 1'b0, 8'h09);
		rchk("rmw", 4'h0, 1'b1, 8'h05);
		check("p4_dig", p4_dig, 4'h8);
		wr(4'h3, 8'h00);
		settle;
		rchk("analog", 4'h0, 1'b0, 8'h01);
		check("an_en", p4_an, 4'hF);
		$display("test input done");
	endtask
	task automatic t_standby;
		wr(4'h3, 8'h0C);
		wr(4'h7, 8'h01);
		rchk("spl", 4'h7, 1'b0, 8'h01);
		@(posedge clk);
		standby <= 1'b1;
		settle;
		check("hiz_oe", p4_oe, 4'h0);
		check("hiz_dig", p4_dig, 4'h0);
		wr(4'h7, 8'h00);
		settle;
		check("keep_oe", p4_oe, 4'h3);
		check("keep_out", p4_out & 4'h3, 4'h1);
		@(posedge clk);
		standby <= 1'b0;
		$display("test standby done");
	endtask
	task automatic t_port5;
		wr(4'h5, 8'h0F);
		wr(4'h4, 8'h0E);
		@(posedge clk);
		p5_poe <= 4'h4;
		p5_pdat <= 4'h0;
		wr(4'h6, 8'h0F);
		settle;
		check("p5_oe", p5_oe, 4'hD);
		check("p5_out", p5_out, 4'h8);
		check("p5_pu", p5_pu, 4'h8);
		rchk("data5", 4'h4, 1'b0, 8'h0E);
		rchk("unmapped", 4'h9, 1'b0, 8'h00);
		// peripheral output off before the pins turn into inputs
		@(posedge clk);
		p5_poe <= 4'h0;
		ext5_en <= 4'h3;
		ext5_val <= 4'h1;
		wr(4'h5, 8'h00);
		settle;
		check("p5_in_oe", p5_oe, 4'h0);
		check("p5_pu_in", p5_pu, 4'hC);
		check("p5_dig", p5_dig, 4'hD);
		rchk("in5", 4'h4, 1'b0, 8'h0D);
		rchk("rmw5", 4'h4, 1'b1, 8'h0E);
		rchk("pull5", 4'h6, 1'b0, 8'h0F);
		$display("test port5 done");
	endtask
	task automatic t_midreset;
		wr(4'h1, 8'h0E);
		wr(4'h0, 8'h03);
		settle;
		check("p4_oe_in0", p4_oe, 4'hE);
		check("p4_drv_in0", p4_out & p4_oe, 4'h2);
		rchk("rmw_in0", 4'h0, 1'b1, 8'h03);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rchk("dir4_rst", 4'h1, 1'b0, 8'h00);
		rchk("dir5_rst", 4'h5, 1'b0, 8'h00);
		rchk("aindis_rst", 4'h3, 1'b0, 8'h00);
		check("p4_oe_rst", p4_oe, 4'h0);
		check("p5_oe_rst", p5_oe, 4'h0);
		check("an_en_rst", p4_an, 4'hF);
		$display("test midreset done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_output;
		t_input;
		t_standby;
		t_port5;
		t_midreset;
		final_report;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report;
	end
endmodule // gpio_port_with_analog_disable_tb_top
